// file: design/l2_parity_events.sv
// page mask, error counters, capture and exception logic
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module l2_parity_events (
   input wire logic SYS_CLK_I, // 10 MHz clock
   input wire logic RESETN_I, // sync reset, active low
   input wire logic [4:0] ADDR_I, // register byte address
   input wire logic [31:0] WDATA_I, // write data
   input wire logic WR_I, // write strobe
   input wire logic RD_I, // read strobe
   output logic [31:0] RDATA_O, // read data, cycle after strobe
   input wire l2_parity_pkg::port_access_t DPORT_I, // data-side access
   input wire l2_parity_pkg::port_access_t PPORT_I, // program-side access
   output l2_parity_pkg::port_ctrl_t DCTRL_O, // data-side parity control
   output l2_parity_pkg::port_ctrl_t PCTRL_O, // program-side control
   output logic CORRECTED_ERROR_EXCEPTION_O, // corrected exception
   output logic UNCORRECTABLE_ERROR_EXCEPTION_O // uncorrectable exception
);
   logic [31:0] mask0_ff, mask1_ff;
   logic [7:0] corr_cnt_ff, uncorr_cnt_ff;
   logic enable_ff;
   logic data_error_flag_ff, program_error_flag_ff, nerr_ff;
   logic [31:0] err_addr_ff;
   logic [31:0] rdata_ff;
   logic corr_exc_ff, uncorr_exc_ff;
   logic d_on, p_on, d_chk, p_chk;
   logic d_se, d_de, p_se, p_de;
   logic wr_cmd, d_clr, p_clr, pending;
   logic any_de, any_se;
   logic cap_data, cap_new;
   logic [31:0] cap_addr;

   function automatic logic page_on(input logic [31:0] a,
                                    input logic [31:0] m0,
                                    input logic [31:0] m1);
      logic [5:0] pg;
      pg = a[l2_parity_pkg::PAGE_IDX_LSB +: 6];
      page_on = pg[5] ? m1[pg[4:0]] : m0[pg[4:0]];
   endfunction

   // global enable and page bit gate everything
   assign d_on = enable_ff && page_on(DPORT_I.addr, mask0_ff, mask1_ff);
   assign p_on = enable_ff && page_on(PPORT_I.addr, mask0_ff, mask1_ff);
   // debug reads never checked
   assign d_chk = d_on && DPORT_I.valid && !DPORT_I.write && !DPORT_I.debug;
   assign p_chk = p_on && PPORT_I.valid && !PPORT_I.write && !PPORT_I.debug;

   always_comb begin
      DCTRL_O.check = d_chk;
      PCTRL_O.check = p_chk;
      // debug writes generate parity as cpu writes do
      DCTRL_O.gen_parity = d_on && DPORT_I.valid && DPORT_I.write;
      PCTRL_O.gen_parity = p_on && PPORT_I.valid && PPORT_I.write;
      DCTRL_O.invalidate = d_on && DPORT_I.valid && DPORT_I.write &&
         DPORT_I.debug &&
         (DPORT_I.width_bytes < 9'(l2_parity_pkg::PACKET_BITS / 8));
      PCTRL_O.invalidate = p_on && PPORT_I.valid && PPORT_I.write &&
         PPORT_I.debug &&
         (PPORT_I.width_bytes < 9'(l2_parity_pkg::PACKET_BITS / 8));
   end

   assign d_de = d_chk && DPORT_I.double_err;
   assign p_de = p_chk && PPORT_I.double_err;
   assign d_se = d_chk && DPORT_I.single_err && !DPORT_I.double_err;
   assign p_se = p_chk && PPORT_I.single_err && !PPORT_I.double_err;
   assign any_de = d_de || p_de;
   assign any_se = d_se || p_se;

   assign wr_cmd = WR_I && (ADDR_I == l2_parity_pkg::OFS_CMD);
   assign d_clr = wr_cmd && WDATA_I[l2_parity_pkg::CMD_DATA_ERROR_CLEAR_CMD_BIT];
   assign p_clr = wr_cmd && WDATA_I[l2_parity_pkg::CMD_PROGRAM_ERROR_CLEAR_CMD_BIT];
   assign pending = data_error_flag_ff || program_error_flag_ff;

   // uncorrectable first, data side before program side
   always_comb begin
      cap_data = 1'b0;
      cap_addr = 32'h00000000;
      if (d_de) begin
         cap_data = 1'b1;
         cap_addr = DPORT_I.addr;
      end else if (p_de) begin
         cap_addr = PPORT_I.addr;
      end else if (d_se) begin
         cap_data = 1'b1;
         cap_addr = DPORT_I.addr;
      end else if (p_se) begin
         cap_addr = PPORT_I.addr;
      end
   end

   // capture when idle, or uncorrectable over a pending correctable
   assign cap_new = (any_de && !nerr_ff) || (any_se && !pending);

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         mask0_ff <= l2_parity_pkg::MASK_RESET;
         mask1_ff <= l2_parity_pkg::MASK_RESET;
      end else if (WR_I && ADDR_I == 5'(l2_parity_pkg::OFS_MASK0)) begin
         mask0_ff <= WDATA_I;
      end else if (WR_I && ADDR_I == 5'(l2_parity_pkg::OFS_MASK1)) begin
         mask1_ff <= WDATA_I;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         enable_ff <= 1'b0;
      end else if (wr_cmd && WDATA_I[l2_parity_pkg::CMD_DIS_BIT]) begin
         enable_ff <= 1'b0;
      end else if (wr_cmd && WDATA_I[l2_parity_pkg::CMD_EN_BIT]) begin
         enable_ff <= 1'b1;
      end
   end

   // a new capture wins over a clear in the same cycle
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         data_error_flag_ff <= 1'b0;
         program_error_flag_ff <= 1'b0;
         nerr_ff <= 1'b0;
         err_addr_ff <= 32'h00000000;
      end else if (cap_new) begin
         data_error_flag_ff <= cap_data;
         program_error_flag_ff <= !cap_data;
         nerr_ff <= any_de;
         err_addr_ff <= cap_addr;
      end else if (d_clr || p_clr) begin
         if (d_clr) begin
            data_error_flag_ff <= 1'b0;
         end
         if (p_clr) begin
            program_error_flag_ff <= 1'b0;
         end
         if ((d_clr || !data_error_flag_ff) && (p_clr || !program_error_flag_ff)) begin
            nerr_ff <= 1'b0;
         end
         err_addr_ff <= 32'h00000000;
      end
   end

   // one-cycle exception pulse per capture
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         corr_exc_ff <= 1'b0;
         uncorr_exc_ff <= 1'b0;
      end else begin
         corr_exc_ff <= cap_new && !any_de;
         uncorr_exc_ff <= cap_new && any_de;
      end
   end
   assign CORRECTED_ERROR_EXCEPTION_O = corr_exc_ff;
   assign UNCORRECTABLE_ERROR_EXCEPTION_O = uncorr_exc_ff;

   // saturating counters; an event in the read cycle restarts at one
   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         corr_cnt_ff <= l2_parity_pkg::CNT_RESET;
      end else if (RD_I && ADDR_I == 5'(l2_parity_pkg::OFS_CORR_CNT)) begin
         corr_cnt_ff <= 8'(any_se);
      end else if (any_se && corr_cnt_ff != l2_parity_pkg::CNT_MAX) begin
         corr_cnt_ff <= corr_cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         uncorr_cnt_ff <= l2_parity_pkg::CNT_RESET;
      end else if (RD_I && ADDR_I == 5'(l2_parity_pkg::OFS_UNCORR_CNT)) begin
         uncorr_cnt_ff <= 8'(any_de);
      end else if (any_de && uncorr_cnt_ff != l2_parity_pkg::CNT_MAX) begin
         uncorr_cnt_ff <= uncorr_cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESETN_I) begin
         rdata_ff <= 32'h00000000;
      end else if (RD_I) begin
         rdata_ff <= 32'h00000000;
         case (ADDR_I)
            5'(l2_parity_pkg::OFS_MASK0): rdata_ff <= mask0_ff;
            5'(l2_parity_pkg::OFS_MASK1): rdata_ff <= mask1_ff;
            5'(l2_parity_pkg::OFS_CORR_CNT): rdata_ff <= {24'h000000, corr_cnt_ff};
            5'(l2_parity_pkg::OFS_UNCORR_CNT): rdata_ff <= {24'h000000, uncorr_cnt_ff};
            l2_parity_pkg::OFS_STATUS: begin
               rdata_ff[l2_parity_pkg::ST_EN_BIT] <= enable_ff;
               rdata_ff[l2_parity_pkg::ST_DATA_ERROR_FLAG_BIT] <= data_error_flag_ff;
               rdata_ff[l2_parity_pkg::ST_PROGRAM_ERROR_FLAG_BIT] <= program_error_flag_ff;
               rdata_ff[l2_parity_pkg::ST_NERR_BIT] <= nerr_ff;
            end
            l2_parity_pkg::OFS_ADDR: rdata_ff <= err_addr_ff;
            default: rdata_ff <= 32'h00000000;
         endcase
      end else begin
         rdata_ff <= 32'h00000000;
      end
   end
   assign RDATA_O = rdata_ff;
endmodule

// file: design/l2_parity_pkg.sv
// constants and types for the l2 parity page mask and error event block
package l2_parity_pkg;
   localparam logic [3:0] OFS_MASK0 = 4'h0;
   localparam logic [3:0] OFS_MASK1 = 4'h4;
   localparam logic [3:0] OFS_CORR_CNT = 4'h8;
   localparam logic [3:0] OFS_UNCORR_CNT = 4'hC;
   localparam logic [4:0] OFS_STATUS = 5'h10;
   localparam logic [4:0] OFS_CMD = 5'h14;
   localparam logic [4:0] OFS_ADDR = 5'h18;
   localparam int ST_EN_BIT = 0;
   localparam int ST_DATA_ERROR_FLAG_BIT = 4;
   localparam int ST_PROGRAM_ERROR_FLAG_BIT = 5;
   localparam int ST_NERR_BIT = 8;
   localparam int CMD_EN_BIT = 0;
   localparam int CMD_DIS_BIT = 2;
   localparam int CMD_DATA_ERROR_CLEAR_CMD_BIT = 4;
   localparam int CMD_PROGRAM_ERROR_CLEAR_CMD_BIT = 5;
   localparam int PAGE_IDX_LSB = 15;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [31:0] MASK_RESET = 32'h00000000;
   localparam int PACKET_BITS = 256;

   // one access on a memory access port
   typedef struct packed {
      logic valid;
      logic write;
      logic debug;
      logic [8:0] width_bytes;
      logic [31:0] addr;
      logic single_err;
      logic double_err;
   } port_access_t;

   // parity controls handed to the memory array
   typedef struct packed {
      logic check;
      logic gen_parity;
      logic invalidate;
   } port_ctrl_t;
endpackage

// file: bench/l2_far_side.sv
// far-side model: caches issuing accesses on both ports
`timescale 1ns/1ps
module l2_far_side (
   input wire logic clk_i, // system clock
   output l2_parity_pkg::port_access_t dport_o, // data-side access
   output l2_parity_pkg::port_access_t pport_o // program-side access
);
   initial begin
      dport_o = '0;
      pport_o = '0;
   end
   // one cycle per access; idle address inverted so it never looks held
   task automatic issue(input l2_parity_pkg::port_access_t d, p);
      @(posedge clk_i);
      dport_o <= d;
      pport_o <= p;
      @(posedge clk_i);
      dport_o <= '{addr: ~d.addr, default: '0};
      pport_o <= '{addr: ~p.addr, default: '0};
   endtask
endmodule

// file: bench/l2_parity_events_chk.sv
// assertions on the ports of the parity event block
`timescale 1ns/1ps
module l2_parity_events_chk (
   input wire logic SYS_CLK_I, // clock
   input wire logic RESETN_I, // sync reset, active low
   input wire logic RD_I, // read strobe
   input wire logic [31:0] RDATA_O, // read data
   input wire l2_parity_pkg::port_access_t DPORT_I, // data side
   input wire l2_parity_pkg::port_access_t PPORT_I, // program side
   input wire l2_parity_pkg::port_ctrl_t DCTRL_O, // data control
   input wire l2_parity_pkg::port_ctrl_t PCTRL_O, // program control
   input wire logic CORRECTED_ERROR_EXCEPTION_O, // corrected
   input wire logic UNCORRECTABLE_ERROR_EXCEPTION_O // uncorrectable
);
   logic ce;
   logic ue;
   assign ce = CORRECTED_ERROR_EXCEPTION_O;
   assign ue = UNCORRECTABLE_ERROR_EXCEPTION_O;
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESETN_I);
   chk_data_gate: assert property (DCTRL_O.check |->
      DPORT_I.valid && !DPORT_I.write && !DPORT_I.debug) else $error("dchk");
   chk_prog_gate: assert property (PCTRL_O.check |->
      PPORT_I.valid && !PPORT_I.write && !PPORT_I.debug) else $error("pchk");
   chk_gen_write: assert property (DCTRL_O.gen_parity |->
      DPORT_I.valid && DPORT_I.write) else $error("gen");
   chk_narrow_inval: assert property (DCTRL_O.invalidate |->
      DPORT_I.debug && DPORT_I.write && DPORT_I.width_bytes < 9'h020)
      else $error("inval");
   chk_corr_cause: assert property (ce |-> $past(DCTRL_O.check &&
      DPORT_I.single_err || PCTRL_O.check && PPORT_I.single_err))
      else $error("ce cause");
   chk_unc_cause: assert property (ue |-> $past(DCTRL_O.check &&
      DPORT_I.double_err || PCTRL_O.check && PPORT_I.double_err))
      else $error("ue cause");
   chk_one_exc: assert property (!(ce && ue)) else $error("both");
   chk_ce_pulse: assert property (ce |=> !ce) else $error("ce");
   chk_ue_pulse: assert property (ue |=> !ue) else $error("ue");
   chk_read_data: assert property (RDATA_O != 32'h0 |-> $past(RD_I))
      else $error("rdata");
   cov_ce: cover property (ce);
   cov_ue: cover property (ue);
   cov_inval: cover property (DCTRL_O.invalidate);
endmodule
bind l2_parity_events l2_parity_events_chk i_chk (.SYS_CLK_I(SYS_CLK_I),
   .RESETN_I(RESETN_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
   .DPORT_I(DPORT_I), .PPORT_I(PPORT_I), .DCTRL_O(DCTRL_O),
   .PCTRL_O(PCTRL_O),
   .CORRECTED_ERROR_EXCEPTION_O(CORRECTED_ERROR_EXCEPTION_O),
   .UNCORRECTABLE_ERROR_EXCEPTION_O(UNCORRECTABLE_ERROR_EXCEPTION_O));

// file: bench/l2_parity_events_tb.sv
// testbench for the parity page mask and error event block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
   bad_count++; $display("FAIL %0t got %0h want %0h", $time, a, e); end end
module l2_parity_events_tb;
   logic SYS_CLK_I = 0, RESETN_I = 0, WR_I = 0, RD_I = 0;
   logic [4:0] ADDR_I = '0;
   logic [31:0] WDATA_I = '0, rdata;
   l2_parity_pkg::port_access_t dport, pport;
   l2_parity_pkg::port_ctrl_t dctrl, pctrl;
   logic ce, ue;
   int bad_count = 0, num_checks = 0, n_ce = 0, n_ue = 0, cycles = 0;
   int n_inv = 0;
   l2_parity_events i_dut (.SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I),
      .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
      .RDATA_O(rdata), .DPORT_I(dport), .PPORT_I(pport), .DCTRL_O(dctrl),
      .PCTRL_O(pctrl), .CORRECTED_ERROR_EXCEPTION_O(ce),
      .UNCORRECTABLE_ERROR_EXCEPTION_O(ue));
   l2_far_side i_far (.clk_i(SYS_CLK_I), .dport_o(dport), .pport_o(pport));
   initial forever #50 SYS_CLK_I = ~SYS_CLK_I;
   task automatic stop_test();
      if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge SYS_CLK_I) begin
      cycles <= cycles + 1;
      if (ce === 1'b1) n_ce <= n_ce + 1;
      if (ue === 1'b1) n_ue <= n_ue + 1;
      if (dctrl.invalidate === 1'b1) n_inv <= n_inv + 1;
      if (cycles == 4000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge SYS_CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      @(posedge SYS_CLK_I);
      WR_I <= 1'b0;
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] m, e);
      @(posedge SYS_CLK_I);
      ADDR_I <= a;
      RD_I <= 1'b1;
      @(posedge SYS_CLK_I);
      RD_I <= 1'b0;
      #1 `CHK(rdata & m, e)
   endtask
   // debug writes go out narrow, everything else as a full 32-byte packet
   function automatic l2_parity_pkg::port_access_t acc(logic w, g,
      logic [31:0] a, logic s, db);
      acc = '{valid: 1'b1, write: w, debug: g, addr: a, single_err: s,
         double_err: db, width_bytes: (w && g) ? 9'h004 : 9'h020};
   endfunction
   task automatic go(input l2_parity_pkg::port_access_t d, p);
      i_far.issue(d, p);
      repeat (2) @(posedge SYS_CLK_I);
      #1;
   endtask
   initial begin
      repeat (4) @(posedge SYS_CLK_I);
      RESETN_I <= 1'b1;
      rdc(5'h00, 32'hFFFFFFFF, 32'h0);
      rdc(5'h08, 32'hFFFFFFFF, 32'h0);
      wr(5'h00, 32'hFFFFFFFF);
      wr(5'h04, 32'hFFFFFFFE);
      rdc(5'h04, 32'hFFFFFFFF, 32'hFFFFFFFE);
      go(acc(0, 0, 32'h8040, 0, 1), '0);
      `CHK(n_ue, 0)
      wr(5'h14, 32'h1);
      rdc(5'h10, 32'h1, 32'h1);
      go(acc(0, 0, 32'h100040, 0, 1), '0);
      `CHK(n_ue, 0)
      go(acc(0, 0, 32'h8040, 1, 0), '0);
      `CHK(n_ce, 1)
      go(acc(0, 0, 32'h8040, 1, 0), '0);
      `CHK(n_ce, 1)
      rdc(5'h10, 32'h30, 32'h10);
      go('0, acc(0, 0, 32'h10040, 0, 1));
      `CHK(n_ue, 1)
      rdc(5'h18, 32'hFFFFFFFF, 32'h10040);
      rdc(5'h08, 32'hFF, 32'h2);
      rdc(5'h08, 32'hFF, 32'h0);
      rdc(5'h0C, 32'hFF, 32'h1);
      wr(5'h14, 32'h31);
      rdc(5'h10, 32'h131, 32'h1);
      rdc(5'h18, 32'hFFFFFFFF, 32'h0);
      go(acc(0, 0, 32'h8040, 1, 0), acc(0, 0, 32'h10040, 0, 1));
      rdc(5'h10, 32'h130, 32'h120);
      wr(5'h14, 32'h31);
      go(acc(0, 0, 32'h8040, 0, 1), acc(0, 0, 32'h10040, 0, 1));
      rdc(5'h10, 32'h130, 32'h110);
      rdc(5'h18, 32'hFFFFFFFF, 32'h8040);
      repeat (260) go(acc(0, 0, 32'h8040, 1, 0), '0);
      `CHK(n_ce, 1)
      rdc(5'h08, 32'hFFFFFFFF, 32'hFF);
      wr(5'h14, 32'h31);
      go(acc(0, 1, 32'h8040, 0, 1), '0);
      `CHK(n_ue, 3)
      go(acc(1, 1, 32'h8040, 0, 0), '0);
      `CHK(n_inv, 1)
      rdc(5'h1C, 32'hFFFFFFFF, 32'h0);
      stop_test();
   end
endmodule
